//--- rxq_adapt.sv
/*
  rxq_adapt: linear equalizer adaptation engine. Sweeps the sixteen boost
  table entries, scores each with the eye merit, applies the best and freezes.
  Assumes one eye measurement arrives per applied code, flagged by eyeValid.
*/
`timescale 1ns/100ps
module rxq_adapt (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // controller side
  rxq_adapt_if.engine ab
);

  typedef enum logic [2:0] {ST_IDLE, ST_SET, ST_MEASURE, ST_APPLY, ST_FROZEN} rxq_ad_state_t;

  rxq_ad_state_t state, next_state;
  logic [rxq_pkg::TIDX_W-1:0] idx, next_idx;
  logic [rxq_pkg::TIDX_W-1:0] next_bestIdx;
  logic [rxq_pkg::SCORE_W-1:0] bestScore, next_bestScore, score;
  logic [rxq_pkg::CODE_W-1:0] next_boostCode;
  logic next_busy, next_frozen;

  assign score = rxq_pkg::merit(ab.horiz, ab.vert); // RULE_04

  // sweep state machine; power loss parks it, start restarts it
  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_bestIdx = ab.bestIdx;
    next_bestScore = bestScore;
    next_boostCode = ab.boostCode;
    if (!ab.powered)
    begin
      next_state = ST_IDLE; // RULE_19
    end
    else if (ab.start)
    begin
      next_state = ST_SET; // RULE_05 RULE_06
      next_idx = '0;
      next_bestIdx = '0;
      next_bestScore = '0;
    end
    else
    begin
      case (state)
        ST_SET:
        begin
          next_boostCode = ab.boostTable[idx]; // RULE_08
          next_state = ST_MEASURE;
        end
        ST_MEASURE:
        begin
          if (ab.eyeValid)
          begin
            if (idx == '0 || score > bestScore)
            begin
              next_bestScore = score; // RULE_04
              next_bestIdx = idx;
            end
            if (idx == rxq_pkg::TIDX_W'(rxq_pkg::TABLE_DEPTH - 1))
              next_state = ST_APPLY;
            else
            begin
              next_idx = idx + 4'h1;
              next_state = ST_SET;
            end
          end
        end
        ST_APPLY:
        begin
          next_boostCode = ab.boostTable[ab.bestIdx];
          next_state = ST_FROZEN;
        end
        ST_FROZEN: next_state = ST_FROZEN; // RULE_05
        ST_IDLE: next_state = ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    end
    next_busy = (next_state == ST_SET) || (next_state == ST_MEASURE) ||
                (next_state == ST_APPLY);
    next_frozen = (next_state == ST_FROZEN);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      idx <= '0;
      ab.bestIdx <= '0;
      bestScore <= '0;
      ab.boostCode <= rxq_pkg::RST_CODE;
      ab.busy <= 1'b0;
      ab.frozen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      ab.bestIdx <= next_bestIdx;
      bestScore <= next_bestScore;
      ab.boostCode <= next_boostCode;
      ab.busy <= next_busy;
      ab.frozen <= next_frozen;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_lastMeasure;
    state == ST_MEASURE && ab.eyeValid && idx == 4'hF && ab.powered && !ab.start;
  endsequence

  a_frozen_holds: assert property ( // RULE_05
    (ab.frozen && !ab.start && ab.powered) |=> $stable(ab.boostCode))
    else $error("boost code moved while frozen");
  a_sweep_uses_table: assert property ( // RULE_08
    (state == ST_SET && !ab.start && ab.powered) |=> (ab.boostCode == $past(ab.boostTable[idx])))
    else $error("sweep code not from table");
  a_sweep_ends_frozen: assert property ( // RULE_04
    s_lastMeasure ##1 ab.powered && !ab.start |=> ab.frozen && ab.boostCode == ab.boostTable[ab.bestIdx])
    else $error("best code not applied after sweep");

endmodule

//--- rxq_adapt_if.sv
/*
  rxq_adapt_if: carries the adaptation request, eye measurements and boost
  table from the channel controller to the adaptation engine, and its results.
  Assumes both ends share mclk.
*/
`timescale 1ns/100ps
interface rxq_adapt_if;
  logic start;
  logic powered;
  logic eyeValid;
  logic [rxq_pkg::EYE_W-1:0] horiz;
  logic [rxq_pkg::EYE_W-1:0] vert;
  logic [rxq_pkg::TABLE_DEPTH-1:0][rxq_pkg::CODE_W-1:0] boostTable;
  logic [rxq_pkg::CODE_W-1:0] boostCode;
  logic busy;
  logic frozen;
  logic [rxq_pkg::TIDX_W-1:0] bestIdx;

  modport ctrl (output start, powered, eyeValid, horiz, vert, boostTable,
                input boostCode, busy, frozen, bestIdx);
  modport engine (input start, powered, eyeValid, horiz, vert, boostTable,
                  output boostCode, busy, frozen, bestIdx);
endinterface

//--- rxq_channel_ctrl.sv
/*
  rxq_channel_ctrl: one channel of receive conditioning control: detector
  gating, linear equalizer adaptation and boost table, gain bits, cross-point
  mode and feedback equalizer settings, behind an AHB-Lite register slave.
  Assumes all inputs are synchronous to mclk; four instances make a device.
*/
`timescale 1ns/100ps
module rxq_channel_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // energy detector and path power
  input wire logic energyPresent,
  output logic pathPowerOn,
  // lock acquisition and eye monitor
  input wire logic lockAcq,
  input wire logic eyeValid,
  input wire logic [rxq_pkg::EYE_W-1:0] horizOpening,
  input wire logic [rxq_pkg::EYE_W-1:0] vertOpening,
  output logic cdrReset,
  // linear equalizer and gain
  output logic [rxq_pkg::CODE_W-1:0] boostCode,
  output logic vgaHighGain,
  output logic leDcGain,
  // feedback equalizer
  output logic [rxq_pkg::NUM_TAPS-1:0] dfeTapEnable,
  output logic dfeAdaptEnable,
  output logic [rxq_pkg::TAPW_BITS-1:0] dfeTapWeight,
  output logic [rxq_pkg::NUM_TAPS-1:0] dfeTapPolarity,
  // pair cross-point
  output logic [1:0] xptMode
);

  // no input from any other channel reaches this controller
  // RULE_01

  rxq_adapt_if ab ();

  // bus state
  logic wrPend, next_wrPend;
  logic [rxq_pkg::IDX_W-1:0] wrIdx, next_wrIdx;
  logic rdPend, next_rdPend;
  logic [rxq_pkg::IDX_W-1:0] rdIdx, next_rdIdx;
  logic next_hreadyout;
  logic [31:0] next_hrdata, rdValue;
  logic addrPhase;
  logic [rxq_pkg::IDX_W-1:0] reqIdx;

  // configuration state
  logic next_leDcGain, next_vgaHighGain;
  logic sdOverride, next_sdOverride, sdForce, next_sdForce;
  logic [1:0] dfeLevel, next_dfeLevel;
  logic dfeAuto, next_dfeAuto, dfeCont, next_dfeCont;
  logic [rxq_pkg::TAPW_BITS-1:0] next_dfeTapWeight;
  logic [rxq_pkg::NUM_TAPS-1:0] next_dfeTapPolarity;
  logic [1:0] next_xptMode;
  logic [rxq_pkg::TABLE_DEPTH-1:0][rxq_pkg::CODE_W-1:0] tbl, next_tbl;

  // event state
  logic lockAcqDly, powerDly, readapt;
  logic next_cdrReset;
  logic [rxq_pkg::NUM_TAPS-1:0] next_dfeTapEnable;
  logic next_dfeAdaptEnable;

  // out-of-range upper address bits, and non-word sizes on writes, map to nothing
  assign addrPhase = hsel && htrans[1] && hready;
  assign reqIdx = (haddr[31:rxq_pkg::ADDR_LSB+rxq_pkg::IDX_W] == '0)
                  ? haddr[rxq_pkg::ADDR_LSB +: rxq_pkg::IDX_W] : rxq_pkg::IDX_NONE;

  // read mux; unmapped and reserved bits read zero
  always_comb
  begin
    rdValue = '0;
    if (rdIdx[7:4] == rxq_pkg::IDX_TABLE_FIRST[7:4])
      rdValue[rxq_pkg::CODE_W-1:0] = tbl[rdIdx[3:0]]; // RULE_08
    else
    begin
      case (rdIdx)
        rxq_pkg::IDX_LE_GAIN: rdValue[rxq_pkg::LE_GAIN_BIT] = leDcGain;
        rxq_pkg::IDX_VGA: rdValue[rxq_pkg::VGA_BIT] = vgaHighGain;
        rxq_pkg::IDX_SIGDET:
        begin
          rdValue[rxq_pkg::SD_OVR_BIT] = sdOverride;
          rdValue[rxq_pkg::SD_FORCE_BIT] = sdForce;
        end
        rxq_pkg::IDX_DFE:
        begin
          rdValue[rxq_pkg::DFE_LEVEL_LSB +: 2] = dfeLevel;
          rdValue[rxq_pkg::DFE_AUTO_BIT] = dfeAuto;
          rdValue[rxq_pkg::DFE_CONT_BIT] = dfeCont;
        end
        rxq_pkg::IDX_TAPS:
        begin
          rdValue[rxq_pkg::TAPW_BITS-1:0] = dfeTapWeight;
          rdValue[rxq_pkg::POL_LSB +: rxq_pkg::NUM_TAPS] = dfeTapPolarity;
        end
        rxq_pkg::IDX_XPT: rdValue[rxq_pkg::XPT_LSB +: 2] = xptMode;
        rxq_pkg::IDX_STATUS:
        begin
          rdValue[rxq_pkg::ST_CODE_LSB +: rxq_pkg::CODE_W] = boostCode;
          rdValue[rxq_pkg::ST_BEST_LSB +: rxq_pkg::TIDX_W] = ab.bestIdx;
          rdValue[rxq_pkg::ST_FROZEN_BIT] = ab.frozen;
          rdValue[rxq_pkg::ST_BUSY_BIT] = ab.busy;
          rdValue[rxq_pkg::ST_POWER_BIT] = pathPowerOn;
        end
        default: rdValue = '0;
      endcase
    end
  end

  // bus slave: writes take no wait, reads one wait state so hrdata is a flop
  always_comb
  begin
    next_wrPend = 1'b0;
    next_wrIdx = wrIdx;
    next_rdPend = 1'b0;
    next_rdIdx = rdIdx;
    next_hreadyout = 1'b1;
    next_hrdata = hrdata;
    if (rdPend)
    begin
      next_hrdata = rdValue;
    end
    else if (addrPhase)
    begin
      if (hwrite)
      begin
        next_wrPend = 1'b1;
        next_wrIdx = (hsize == rxq_pkg::SIZE_WORD) ? reqIdx : rxq_pkg::IDX_NONE;
      end
      else
      begin
        next_rdPend = 1'b1;
        next_rdIdx = reqIdx;
        next_hreadyout = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend <= 1'b0;
      wrIdx <= rxq_pkg::IDX_NONE;
      rdPend <= 1'b0;
      rdIdx <= rxq_pkg::IDX_NONE;
      hreadyout <= 1'b1;
      hresp <= rxq_pkg::HRESP_OKAY;
      hrdata <= '0;
    end
    else
    begin
      wrPend <= next_wrPend;
      wrIdx <= next_wrIdx;
      rdPend <= next_rdPend;
      rdIdx <= next_rdIdx;
      hreadyout <= next_hreadyout;
      hresp <= rxq_pkg::HRESP_OKAY;
      hrdata <= next_hrdata;
    end
  end

  // register writes land at the end of the data phase
  always_comb
  begin
    next_leDcGain = leDcGain;
    next_vgaHighGain = vgaHighGain;
    next_sdOverride = sdOverride;
    next_sdForce = sdForce;
    next_dfeLevel = dfeLevel;
    next_dfeAuto = dfeAuto;
    next_dfeCont = dfeCont;
    next_dfeTapWeight = dfeTapWeight;
    next_dfeTapPolarity = dfeTapPolarity;
    next_xptMode = xptMode;
    next_tbl = tbl;
    if (wrPend && wrIdx[7:4] == rxq_pkg::IDX_TABLE_FIRST[7:4])
    begin
      // any of the 256 codes may sit in any entry
      next_tbl[wrIdx[3:0]] = hwdata[rxq_pkg::CODE_W-1:0]; // RULE_07 RULE_08
    end
    else if (wrPend)
    begin
      case (wrIdx)
        rxq_pkg::IDX_LE_GAIN: next_leDcGain = hwdata[rxq_pkg::LE_GAIN_BIT]; // RULE_10
        rxq_pkg::IDX_VGA: next_vgaHighGain = hwdata[rxq_pkg::VGA_BIT]; // RULE_09
        rxq_pkg::IDX_SIGDET:
        begin
          next_sdOverride = hwdata[rxq_pkg::SD_OVR_BIT]; // RULE_03
          next_sdForce = hwdata[rxq_pkg::SD_FORCE_BIT];
        end
        rxq_pkg::IDX_DFE:
        begin
          next_dfeLevel = hwdata[rxq_pkg::DFE_LEVEL_LSB +: 2]; // RULE_15
          next_dfeAuto = hwdata[rxq_pkg::DFE_AUTO_BIT];
          next_dfeCont = hwdata[rxq_pkg::DFE_CONT_BIT]; // RULE_13
        end
        rxq_pkg::IDX_TAPS:
        begin
          // field widths cap tap 1 at 31 and taps 2-5 at 15
          next_dfeTapWeight = hwdata[rxq_pkg::TAPW_BITS-1:0]; // RULE_17
          next_dfeTapPolarity = hwdata[rxq_pkg::POL_LSB +: rxq_pkg::NUM_TAPS]; // RULE_18
        end
        rxq_pkg::IDX_XPT: next_xptMode = hwdata[rxq_pkg::XPT_LSB +: 2]; // RULE_11
        default: next_xptMode = xptMode;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      leDcGain <= rxq_pkg::RST_BIT;
      vgaHighGain <= rxq_pkg::RST_BIT; // RULE_09
      sdOverride <= rxq_pkg::RST_BIT; // RULE_03
      sdForce <= rxq_pkg::RST_BIT;
      dfeLevel <= rxq_pkg::DFE_OFF; // RULE_12
      dfeAuto <= rxq_pkg::RST_BIT;
      dfeCont <= rxq_pkg::RST_BIT;
      dfeTapWeight <= rxq_pkg::RST_TAPW;
      dfeTapPolarity <= rxq_pkg::RST_POL;
      xptMode <= rxq_pkg::XPT_THRU;
      for (int i = 0; i < rxq_pkg::TABLE_DEPTH; i++)
        tbl[i] <= rxq_pkg::table_reset(rxq_pkg::TIDX_W'(i));
    end
    else
    begin
      leDcGain <= next_leDcGain;
      vgaHighGain <= next_vgaHighGain;
      sdOverride <= next_sdOverride;
      sdForce <= next_sdForce;
      dfeLevel <= next_dfeLevel;
      dfeAuto <= next_dfeAuto;
      dfeCont <= next_dfeCont;
      dfeTapWeight <= next_dfeTapWeight;
      dfeTapPolarity <= next_dfeTapPolarity;
      xptMode <= next_xptMode;
      tbl <= next_tbl;
    end
  end

  // self-clearing command bits; re-adapt never reaches a flop of its own
  assign readapt = wrPend && wrIdx == rxq_pkg::IDX_CTRL && hwdata[rxq_pkg::CTRL_READAPT_BIT];

  // events and feedback enables; tap n weighs the decision n bits back
  always_comb
  begin
    next_cdrReset = wrPend && wrIdx == rxq_pkg::IDX_CTRL &&
                    hwdata[rxq_pkg::CTRL_CDR_RST_BIT];
    next_dfeTapEnable = rxq_pkg::tap_mask(dfeLevel); // RULE_12 RULE_15 RULE_16
    next_dfeAdaptEnable = dfeAuto && (next_dfeTapEnable != rxq_pkg::MASK_NONE) &&
                          pathPowerOn && (dfeCont || lockAcq); // RULE_13 RULE_14
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cdrReset <= 1'b0;
      dfeTapEnable <= rxq_pkg::MASK_NONE;
      dfeAdaptEnable <= 1'b0;
      lockAcqDly <= 1'b0;
      powerDly <= 1'b0;
    end
    else
    begin
      cdrReset <= next_cdrReset;
      dfeTapEnable <= next_dfeTapEnable;
      dfeAdaptEnable <= next_dfeAdaptEnable;
      lockAcqDly <= lockAcq;
      powerDly <= pathPowerOn;
    end
  end

  // adaptation starts on acquisition entry, re-adapt, recovery reset or power return
  assign ab.start = (lockAcq && !lockAcqDly) || readapt || next_cdrReset ||
                    (pathPowerOn && !powerDly); // RULE_05 RULE_06 RULE_19
  assign ab.powered = pathPowerOn;
  assign ab.eyeValid = eyeValid;
  assign ab.horiz = horizOpening;
  assign ab.vert = vertOpening;
  assign ab.boostTable = tbl;
  assign boostCode = ab.boostCode;

  rxq_sigdet u_sigdet (
    .mclk(mclk),
    .rst_n(rst_n),
    .energyPresent(energyPresent),
    .overrideEn(sdOverride),
    .forceOn(sdForce),
    .powerOn(pathPowerOn)
  );

  rxq_adapt u_adapt (
    .mclk(mclk),
    .rst_n(rst_n),
    .ab(ab.engine)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_vgaWrite;
    wrPend && (wrIdx == rxq_pkg::IDX_VGA);
  endsequence
  sequence s_readAddr;
    addrPhase && !hwrite && !rdPend;
  endsequence

  a_vga_write_lands: assert property ( // RULE_09
    s_vgaWrite |=> (vgaHighGain == $past(hwdata[rxq_pkg::VGA_BIT])))
    else $error("gain bit did not take written value");
  a_read_one_wait: assert property (
    s_readAddr |=> !hreadyout ##1 (hreadyout && hrdata == $past(rdValue)))
    else $error("read data phase not one wait state");
  a_dfe_off_level: assert property ( // RULE_12
    (dfeLevel == rxq_pkg::DFE_OFF) |=> (dfeTapEnable == rxq_pkg::MASK_NONE && !dfeAdaptEnable))
    else $error("feedback taps active while off");
  a_dfe_two_taps: assert property ( // RULE_15
    (dfeLevel == rxq_pkg::DFE_TAPS12) |=> (dfeTapEnable == rxq_pkg::MASK_12))
    else $error("partial level not taps one and two");
  a_dfe_adapt_mode: assert property ( // RULE_13
    (!dfeCont && !lockAcq) |=> !dfeAdaptEnable)
    else $error("feedback adapts outside acquisition");
  a_sd_force_off: assert property ( // RULE_03
    (sdOverride && !sdForce) |=> !pathPowerOn)
    else $error("forced-off path still powered");
  a_sd_auto: assert property ( // RULE_02
    !sdOverride |=> (pathPowerOn == $past(energyPresent)))
    else $error("path power does not follow detector");
  a_cdr_readapt: assert property ( // RULE_06
    (cdrReset && $past(pathPowerOn) && pathPowerOn) |-> ab.busy ##[1:40] ab.busy || ab.frozen)
    else $error("recovery reset did not restart adaptation");
  a_idle_unpowered: assert property ( // RULE_19
    !pathPowerOn |=> (!ab.busy && !ab.frozen))
    else $error("adaptation active while unpowered");

endmodule

//--- rxq_channel_ctrl_bench.sv
/*
  rxq_channel_ctrl_bench: self-checking bench for one channel controller.
  Assumes the bench is the only bus master and plays the eye monitor.
*/
`timescale 1ns/100ps
module rxq_channel_ctrl_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic energyPresent = 1'b0;
  logic lockAcq = 1'b0;
  logic eyeValid = 1'b0;
  logic [7:0] horiz = 8'h00;
  logic hreadyout, hresp, pathPowerOn, cdrReset, vgaHighGain, leDcGain, dfeAdaptEnable;
  logic [1:0] xptMode;
  logic [4:0] dfeTapEnable, dfeTapPolarity;
  logic [7:0] boostCode;
  logic [20:0] dfeTapWeight;
  logic [31:0] hrdata, rd;
  int errors = 0;
  int samples_checked = 0;
  int cdrPulses = 0;

  // free-running clock; watchdog closes the run if anything hangs
  always #2.5 mclk = ~mclk;
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    results();
  end

  // recovery reset is a one-cycle pulse, so count it at every edge
  always @(posedge mclk)
  begin
    if (cdrReset === 1'b1)
      cdrPulses++;
  end

  rxq_channel_ctrl rxq_channel_ctrl_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(rxq_pkg::SIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .energyPresent(energyPresent), .pathPowerOn(pathPowerOn),
    .lockAcq(lockAcq), .eyeValid(eyeValid), .horizOpening(horiz), .vertOpening(8'h40),
    .cdrReset(cdrReset), .boostCode(boostCode), .vgaHighGain(vgaHighGain),
    .leDcGain(leDcGain), .dfeTapEnable(dfeTapEnable), .dfeAdaptEnable(dfeAdaptEnable),
    .dfeTapWeight(dfeTapWeight), .dfeTapPolarity(dfeTapPolarity), .xptMode(xptMode));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a wait that used up its bound counts once and ends the run
  task automatic expire(input logic ok);
    if (!ok)
    begin
      errors++;
      results();
    end
  endtask

  // one word transfer; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    for (n = 0; n == 0 || (hreadyout !== 1'b1 && n < 20); n++) @(posedge mclk);
    expire(hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    for (n = 0; n == 0 || (hreadyout !== 1'b1 && n < 20); n++) @(posedge mclk);
    expire(hreadyout === 1'b1);
    rd = hrdata;
    chk("hresp", 0, hresp);
    repeat (2) @(negedge mclk);
  endtask

  // bounded wait for a boost code, judged on a settled edge
  task automatic waitCode(input logic [7:0] e);
    for (int n = 0; n < 40 && boostCode !== e; n++) @(negedge mclk);
    chk("boostCode", e, boostCode);
    if (boostCode !== e)
      results();
  endtask

  task automatic t_regs();
    bus(0, 8'h43, 0);
    chk("table3", 32'h33, rd);
    bus(0, 8'h8E, 0);
    chk("vga", 0, rd);
    bus(0, 8'hFF, 0);
    chk("unmapped", 0, rd);
    chk("tapEn", 0, dfeTapEnable);
    bus(1, 8'h8E, 1);
    chk("vgaOut", 1, vgaHighGain);
    bus(1, 8'h13, 32'h20);
    chk("leGain", 1, leDcGain);
    bus(1, 8'h93, 32'h2BFFFFF);
    chk("weight", 32'h1FFFFF, dfeTapWeight);
    chk("polarity", 5'h15, dfeTapPolarity);
    for (int m = 0; m < 4; m++)
    begin
      bus(1, 8'h94, m);
      chk("xpt", m, xptMode);
    end
  endtask

  task automatic t_power();
    chk("pwrOff", 0, pathPowerOn);
    @(posedge mclk) energyPresent <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("pwrOn", 1, pathPowerOn);
    bus(1, 8'h90, 1);
    chk("forcedOff", 0, pathPowerOn);
    bus(1, 8'h90, 0);
    chk("auto", 1, pathPowerOn);
  endtask

  // every level with auto and continuous set, then auto without continuous
  task automatic t_dfe();
    logic [4:0] m[4] = '{5'h00, 5'h03, 5'h1F, 5'h00};
    for (int l = 0; l < 4; l++)
    begin
      bus(1, 8'h92, 32'hC | l);
      chk("tapEn", m[l], dfeTapEnable);
      chk("adaptEn", (l == 1 || l == 2), dfeAdaptEnable);
    end
    bus(1, 8'h92, 32'h6);
    chk("acqOnly", 0, dfeAdaptEnable);
  endtask

  // sweep with a peak at entry 9 tied by entry 12; earlier entry must win
  task automatic t_adapt();
    for (int i = 0; i < 16; i++) bus(1, 8'h40 + i, 8'hA0 + i);
    @(posedge mclk) lockAcq <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      waitCode(8'hA0 + i);
      @(posedge mclk);
      eyeValid <= 1'b1;
      horiz <= (i == 9 || i == 12) ? 8'hC0 : 8'h40;
      @(posedge mclk);
      eyeValid <= 1'b0;
    end
    waitCode(8'hA9);
    @(posedge mclk) lockAcq <= 1'b0;
    repeat (8) @(negedge mclk);
    chk("frozen", 8'hA9, boostCode);
    bus(1, 8'h91, 1);
    waitCode(8'hA0);
    // entry 0 changes under a running sweep; only a restart picks it up
    bus(1, 8'h40, 8'h5A);
    bus(1, 8'h91, 2);
    waitCode(8'h5A);
    chk("cdrPulses", 1, cdrPulses);
    @(posedge mclk) energyPresent <= 1'b0;
    bus(0, 8'h95, 0);
    chk("busyOff", 0, rd[14:13]);
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_power();
    t_dfe();
    t_adapt();
    results();
  end
endmodule

//--- rxq_pkg.sv
/*
  rxq_pkg: constants, register indices, field positions and helper functions
  for one receive-conditioning channel controller.
  Assumes a 32-bit AHB-Lite bus where each register takes one word and the
  byte address is four times the register index.
*/
// What this block does
// RULE_01: each channel controller runs fully on its own
// RULE_02: energy detector powers high-speed path on/off
// RULE_03: auto gating default; software may force detector
// RULE_04: sweep boost codes, keep best eye merit
// RULE_05: boost frozen until re-adapt or lock acquisition
// RULE_06: clock recovery reset restarts equalizer adaptation
// RULE_07: boost code is four two-bit stages
// RULE_08: sweep only sixteen table entries 0x40-0x4F
// RULE_09: amplifier gain bit 0 of 0x8E, reset low
// RULE_10: equalizer dc gain at bit 5 of 0x13
// RULE_11: pair cross-point: mux, fanout or lane swap
// RULE_12: feedback equalizer off until software enables it
// RULE_13: feedback adaptation during acquisition or continuously
// RULE_14: software disables auto-adapt before manual tap writes
// RULE_15: feedback levels: taps 1-5, taps 1-2, none
// RULE_16: feedback taps one bit apart on past decisions
// RULE_17: tap 1 weight 0-31, taps 2-5 0-15
// RULE_18: polarity 0 low-pass positive, 1 high-pass negative
// RULE_19: no adaptation while unpowered; restart on return
package rxq_pkg;

  // structure
  localparam int TABLE_DEPTH = 16;
  localparam int TIDX_W = 4;
  localparam int STAGES = 4;
  localparam int STAGE_W = 2;
  localparam int CODE_W = STAGES * STAGE_W;
  localparam int EYE_W = 8;
  localparam int SCORE_W = EYE_W + 1;
  localparam int NUM_TAPS = 5;
  localparam int TAP1_W = 5;
  localparam int TAPN_W = 4;
  localparam int TAPW_BITS = TAP1_W + (NUM_TAPS - 1) * TAPN_W;

  // bus decode
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_LE_GAIN = 8'h13;
  localparam logic [7:0] IDX_TABLE_FIRST = 8'h40;
  localparam logic [7:0] IDX_TABLE_LAST = 8'h4F;
  localparam logic [7:0] IDX_VGA = 8'h8E;
  localparam logic [7:0] IDX_SIGDET = 8'h90;
  localparam logic [7:0] IDX_CTRL = 8'h91;
  localparam logic [7:0] IDX_DFE = 8'h92;
  localparam logic [7:0] IDX_TAPS = 8'h93;
  localparam logic [7:0] IDX_XPT = 8'h94;
  localparam logic [7:0] IDX_STATUS = 8'h95;
  localparam logic [7:0] IDX_NONE = 8'hFF;

  // field positions
  localparam int LE_GAIN_BIT = 5;
  localparam int VGA_BIT = 0;
  localparam int SD_OVR_BIT = 0;
  localparam int SD_FORCE_BIT = 1;
  localparam int CTRL_READAPT_BIT = 0;
  localparam int CTRL_CDR_RST_BIT = 1;
  localparam int DFE_LEVEL_LSB = 0;
  localparam int DFE_AUTO_BIT = 2;
  localparam int DFE_CONT_BIT = 3;
  localparam int POL_LSB = TAPW_BITS;
  localparam int XPT_LSB = 0;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_BEST_LSB = 8;
  localparam int ST_FROZEN_BIT = 12;
  localparam int ST_BUSY_BIT = 13;
  localparam int ST_POWER_BIT = 14;

  // feedback equalizer enable levels and tap masks
  localparam logic [1:0] DFE_OFF = 2'h0;
  localparam logic [1:0] DFE_TAPS12 = 2'h1;
  localparam logic [1:0] DFE_ALL = 2'h2;
  localparam logic [NUM_TAPS-1:0] MASK_NONE = 5'h00;
  localparam logic [NUM_TAPS-1:0] MASK_12 = 5'h03;
  localparam logic [NUM_TAPS-1:0] MASK_ALL = 5'h1F;

  // cross-point modes
  localparam logic [1:0] XPT_THRU = 2'h0;
  localparam logic [1:0] XPT_MUX = 2'h1;
  localparam logic [1:0] XPT_FANOUT = 2'h2;
  localparam logic [1:0] XPT_SWAP = 2'h3;

  // reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [TAPW_BITS-1:0] RST_TAPW = '0;
  localparam logic [NUM_TAPS-1:0] RST_POL = '0;
  localparam logic [CODE_W-1:0] RST_CODE = 8'h00;

  // tap enable mask for a level; the spare encoding means off
  function automatic logic [NUM_TAPS-1:0] tap_mask(input logic [1:0] level);
    case (level)
      DFE_TAPS12: return MASK_12;
      DFE_ALL: return MASK_ALL;
      default: return MASK_NONE;
    endcase
  endfunction

  // eye merit score from both openings
  function automatic logic [SCORE_W-1:0] merit(input logic [EYE_W-1:0] h,
                                               input logic [EYE_W-1:0] v);
    return {1'b0, h} + {1'b0, v};
  endfunction

  // default boost table entry: index repeated in both nibbles
  function automatic logic [CODE_W-1:0] table_reset(input logic [TIDX_W-1:0] i);
    return {i, i};
  endfunction

endpackage

//--- rxq_sigdet.sv
/*
  rxq_sigdet: power gating of the high-speed path from the energy detector,
  with a software override.
  Assumes energyPresent is synchronous to mclk.
*/
`timescale 1ns/100ps
module rxq_sigdet (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // detector and override
  input wire logic energyPresent,
  input wire logic overrideEn,
  input wire logic forceOn,
  // gate
  output logic powerOn
);

  logic next_powerOn;

  // forced state wins only while the override is set
  always_comb
  begin
    next_powerOn = energyPresent; // RULE_02
    if (overrideEn)
    begin
      next_powerOn = forceOn; // RULE_03
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      powerOn <= 1'b0;
    else
      powerOn <= next_powerOn;
  end

endmodule
